/* File: rtl/hlc_link_unit.sv */
`timescale 1ns/100ps
`include "hlc_regs.svh"
////////////////////////////////////////////////////////////////////////////
module hlc_link_unit (
	// clock and reset
	input  wire logic      mclk,
	input  wire logic      rst_n,
	// microprocessor register port
	input  hlc_pkg::hlc_bus_t bus,
	output logic [7:0]     bus_rdata,
	// serial data link pins
	input  wire logic      rx_clk_pin,
	input  wire logic      rx_data_pin,
	input  wire logic      tx_clk_pin,
	output logic           tx_data_pin,
	// status
	output logic           rx_idle,
	output logic           tx_idle,
	output logic           unit_irq
);
	hlc_pkg::hlc_st_t      q, d;
	hlc_pkg::hlc_tx_ent_t  tx_ent, tx_head;
	hlc_pkg::hlc_rx_ent_t  rx_ent, rx_head, sk_data;
	hlc_pkg::hlc_tx_st_t   nst;
	logic [7:0]            tx_cnt, rx_cnt, stat, byte_n;
	logic [15:0]           nsh;
	logic [4:0]            nn;
	logic [3:0]            ones_n;
	logic                  wr, rd, tx_push, tx_pop, rx_pop, tx_full;
	logic                  tx_valid, rx_valid, rx_full, sk_ready, sk_valid;
	logic                  rx_go, rx_flag, rx_abort, rx_stz, rx_pend;
	logic                  rx_push, tx_go, tb, hv, load, eb;

	assign bus_rdata   = q.rdata;
	assign tx_data_pin = q.txo;
	assign rx_idle     = q.rx_idle;
	assign tx_idle     = q.tx_idle;
	assign unit_irq    = q.irq;

	////////////////////////////////////////////////////////////////////////
	// reflected crc-16 step, one bit
	function automatic logic [15:0] hlc_crc(input logic [15:0] c,
		input logic b);
		hlc_crc = {1'b0, c[15:1]} ^ ((c[0] ^ b) ? `HLC_CRC_POLY : 16'h0000);
	endfunction : hlc_crc

	// threshold code to byte count
	function automatic logic [7:0] hlc_thr(input logic [2:0] c);
		hlc_thr = {1'b0, c, 4'h0} + `HLC_THR_STEP;
	endfunction : hlc_thr
	function automatic logic rx_bit(input hlc_pkg::hlc_st_t s);
		rx_bit = s.ctrl1[`HLC_C1_LOOP_TR] ? s.line : s.rxd[1];
	endfunction : rx_bit

	////////////////////////////////////////////////////////////////////////
	// next-state logic for registers, receiver and transmitter
	always_comb begin
		d        = q;
		wr       = bus.sel & bus.wr;
		rd       = bus.sel & bus.rd;
		rx_flag  = 1'b0;
		rx_abort = 1'b0;
		rx_stz   = 1'b0;
		rx_pend  = 1'b0;
		rx_push  = 1'b0;
		rx_ent   = '0;
		ones_n   = q.ones;
		byte_n   = q.sr;
		eb       = 1'b0;
		tb       = 1'b1;
		hv       = 1'b0;
		load     = 1'b0;
		tx_pop   = 1'b0;
		nst      = q.tst;
		nsh      = q.sh;
		nn       = q.n;
		// pin synchronisers
		d.rxc = {q.rxc[1:0], rx_clk_pin};
		d.rxd = {q.rxd[0], rx_data_pin};
		d.txc = {q.txc[1:0], tx_clk_pin};
		// bit events, each side on its own link clock except the receiver in transmit loopback
		tx_go = q.txc[1] & ~q.txc[2] & q.sel & ~q.srst &
			(q.ctrl1[`HLC_C1_TX_EN] | (q.tst != hlc_pkg::TX_MARK));
		rx_go = (q.ctrl1[`HLC_C1_LOOP_TR] ? tx_go : (q.rxc[1] & ~q.rxc[2]))
			& q.sel & ~q.srst & (q.ctrl1[`HLC_C1_RX_EN] | q.in_frame);

		// register writes and transmit fifo loading
		tx_push = wr & (bus.addr == `HLC_OFS_FIFO) & ~tx_full;
		tx_ent.data  = bus.wdata;
		tx_ent.abort = q.ctrl1[`HLC_C1_FA];
		tx_ent.endp  = q.ctrl1[`HLC_C1_EOP] | (q.count == 8'h01);
		if (wr) begin
			case (bus.addr)
				`HLC_OFS_CTRL1: d.ctrl1 = bus.wdata;
				`HLC_OFS_CTRL2: d.ctrl2 = bus.wdata;
				`HLC_OFS_STAT:  d.sel   = bus.wdata[`HLC_SEL_BIT];
				`HLC_OFS_SRST:  d.srst  = bus.wdata[`HLC_SRST_BIT];
				`HLC_OFS_COUNT: begin
					d.count  = bus.wdata;
					d.cnt_ld = bus.wdata;
				end
				default: ;
			endcase
		end
		if (tx_push) begin
			d.ctrl1[`HLC_C1_EOP] = 1'b0;
			d.ctrl1[`HLC_C1_FA]  = 1'b0;
			if (q.count == 8'h01)
				d.count = q.ctrl2[`HLC_C2_CYCLE] ? q.cnt_ld : 8'h00;
			else if (q.count != 8'h00)
				d.count = q.count - 8'h01;
		end

		// status read shows the flags of the byte at the head of the receive fifo
		stat = 8'h00;
		stat[`HLC_ST_LAST]    = rx_valid & rx_head.last;
		stat[`HLC_ST_BAD]     = rx_valid & rx_head.bad;
		stat[`HLC_ST_AVAIL]   = rx_valid;
		stat[`HLC_ST_NFULL]   = q.nfull;
		stat[`HLC_ST_NEMPTY]  = q.nempty;
		stat[`HLC_ST_UNDER]   = q.underrun;
		stat[`HLC_ST_OVFL]    = q.overflow;
		stat[`HLC_ST_GOAHEAD] = q.goahead;
		rx_pop = rd & (bus.addr == `HLC_OFS_FIFO) & rx_valid;
		if (rd) begin
			case (bus.addr)
				`HLC_OFS_CTRL1: d.rdata = q.ctrl1;
				`HLC_OFS_CTRL2: d.rdata = q.ctrl2;
				`HLC_OFS_STAT:  d.rdata = stat;
				`HLC_OFS_FIFO:  d.rdata = rx_valid ? rx_head.data : 8'h00;
				`HLC_OFS_COUNT: d.rdata = q.count;
				`HLC_OFS_SRST:  d.rdata = {q.srst, 7'h00};
				default:        d.rdata = 8'h00;
			endcase
		end
		// reading status clears the sticky events; a new event wins below
		if (rd && (bus.addr == `HLC_OFS_STAT)) begin
			d.underrun = 1'b0;
			d.overflow = 1'b0;
			d.goahead  = 1'b0;
		end
		d.nfull  = rx_cnt >= hlc_thr(q.ctrl2[`HLC_C2_RX_THR]);
		d.nempty = tx_cnt <= hlc_thr(q.ctrl2[`HLC_C2_TX_THR]);

		// receiver: flag hunt, zero deletion, bytes held three deep
		if (rx_go) begin
			rx_flag  = ~q.ones[3] & (q.ones == `HLC_RUN_SIX) & ~rx_bit(q);
			rx_abort = (q.ones == `HLC_RUN_SIX) & rx_bit(q);
			rx_stz = ~rx_bit(q) & (q.ones == `HLC_RUN_STUFF) & q.in_frame;
			ones_n = ~rx_bit(q) ? 4'h0 :
				(q.ones == `HLC_RUN_IDLE) ? q.ones : q.ones + 4'h1;
			d.ones    = ones_n;
			d.rx_idle = (ones_n == `HLC_RUN_IDLE);
			if (~rx_bit(q) && (q.ones == `HLC_RUN_SEVEN))
				d.goahead = 1'b1;
			if (rx_flag) begin
				if (q.in_frame && (q.bits >= `HLC_MIN_BITS)
					&& (q.hcnt != 2'h0)) begin
					rx_pend     = 1'b1;
					rx_ent.data = q.h0;
					rx_ent.last = 1'b1;
					rx_ent.bad  = ~((q.bits >= `HLC_GOOD_BITS)
						&& (q.rcrc == `HLC_CRC_GOOD));
				end
				d.in_frame = 1'b1;
				d.blocked  = 1'b0;
				d.wcnt     = 3'h0;
				d.bits     = 6'h00;
				d.bpos     = 3'h0;
				d.hcnt     = 2'h0;
				d.rcrc     = `HLC_CRC_INIT;
			end else if (rx_abort) begin
				if (q.in_frame && (q.bits >= `HLC_ABORT_BITS)
					&& (q.hcnt != 2'h0)) begin
					rx_pend     = 1'b1;
					rx_ent.data = q.h0;
					rx_ent.last = 1'b1;
					rx_ent.bad  = 1'b1;
				end
				d.in_frame = 1'b0;
			end else if (ones_n == `HLC_RUN_IDLE) begin
				d.in_frame = 1'b0;
			end else if (q.in_frame && !rx_stz) begin
				// seven-bit delay keeps flag bits out of data and crc
				d.win = {rx_bit(q), q.win[6:1]};
				if (q.wcnt != 3'h7) begin
					d.wcnt = q.wcnt + 3'h1;
				end else begin
					eb     = q.win[0];
					d.rcrc = hlc_crc(q.rcrc, eb);
					if (q.bits != 6'h3f)
						d.bits = q.bits + 6'h01;
					byte_n = {eb, q.sr[7:1]};
					d.sr   = byte_n;
					d.bpos = q.bpos + 3'h1;
					if (q.bpos == 3'h7) begin
						if (q.hcnt == 2'h3) begin
							rx_pend     = 1'b1;
							rx_ent.data = q.h0;
							d.h0 = q.h1;
							d.h1 = q.h2;
							d.h2 = byte_n;
						end else begin
							case (q.hcnt)
								2'h0:    d.h0 = byte_n;
								2'h1:    d.h1 = byte_n;
								default: d.h2 = byte_n;
							endcase
							d.hcnt = q.hcnt + 2'h1;
						end
					end
				end
			end
		end
		// store through the buffer; a refusal is an overflow
		if (rx_pend && !q.blocked) begin
			if (sk_ready) begin
				rx_push = 1'b1;
			end else begin
				d.overflow = 1'b1;
				d.blocked  = 1'b1;
			end
		end

		// transmitter: one unit (flag, data, check, abort, ones) at a time
		if (tx_go) begin
			if (((q.tst == hlc_pkg::TX_DATA) || (q.tst == hlc_pkg::TX_FCS))
				&& (q.tones == `HLC_TX_STUFF)) begin
				tb = 1'b0;
			end else begin
				if (q.n == 5'h00) begin
					// default is the idle style
					nst = q.ctrl1[`HLC_C1_IDLE] ? hlc_pkg::TX_FLAG
						: hlc_pkg::TX_MARK;
					nsh = {8'h00, q.ctrl1[`HLC_C1_IDLE] ? `HLC_FLAG
						: `HLC_ONES};
					nn  = 5'h08;
					d.tcrc = `HLC_CRC_INIT;
					hv = tx_valid & q.ctrl1[`HLC_C1_TX_EN];
					case (q.tst)
						hlc_pkg::TX_DATA: begin
							if (q.last_end) begin
								nst = hlc_pkg::TX_FLAG;
								nsh = {8'h00, `HLC_FLAG};
								if (!q.ctrl2[`HLC_C2_CRC_INH]) begin
									nst = hlc_pkg::TX_FCS;
									nsh = ~q.tcrc;
									nn  = 5'h10;
								end
							end else if (tx_valid) begin
								load = 1'b1;
							end else begin
								d.underrun = 1'b1;
								nst = hlc_pkg::TX_ABORT;
								nsh = {8'h00, `HLC_ABORT_PAT};
							end
						end
						hlc_pkg::TX_FCS: begin
							nst = hlc_pkg::TX_FLAG;
							nsh = {8'h00, `HLC_FLAG};
						end
						hlc_pkg::TX_FLAG: load = hv;
						hlc_pkg::TX_MARK: begin
							if (hv) begin
								nst = hlc_pkg::TX_FLAG;
								nsh = {8'h00, `HLC_FLAG};
							end
						end
						default: ;
					endcase
					if (load) begin
						tx_pop = 1'b1;
						if (tx_head.abort) begin
							nst = hlc_pkg::TX_ABORT;
							nsh = {8'h00, `HLC_ABORT_PAT};
						end else begin
							nst = hlc_pkg::TX_DATA;
							nsh = {8'h00, tx_head.data};
							d.last_end = tx_head.endp;
							d.tcrc = q.tcrc;
						end
					end
				end
				tb  = nsh[0];
				nsh = {1'b0, nsh[15:1]};
				nn  = nn - 5'h01;
				if (nst == hlc_pkg::TX_DATA)
					d.tcrc = hlc_crc(d.tcrc, tb);
			end
			d.tst   = nst;
			d.sh    = nsh;
			d.n     = nn;
			d.tones = (tb && ((nst == hlc_pkg::TX_DATA)
				|| (nst == hlc_pkg::TX_FCS))) ? q.tones + 3'h1 : 3'h0;
			d.line  = tb;
			d.lones = !tb ? 4'h0 : (q.lones == `HLC_RUN_IDLE) ? q.lones
				: q.lones + 4'h1;
			d.tx_idle = (d.lones == `HLC_RUN_IDLE);
		end
		d.txo = q.ctrl1[`HLC_C1_LOOP_RT] ? q.rxd[1] : d.line;
		d.irq = q.sel & (q.nfull | q.nempty | q.underrun | q.overflow);
		// soft reset holds control cleared and engines parked
		if (q.srst) begin
			d.ctrl1    = 8'h00;
			d.ctrl2    = 8'h00;
			d.count    = 8'h00;
			d.cnt_ld   = 8'h00;
			d.in_frame = 1'b0;
			d.tst      = hlc_pkg::TX_MARK;
			d.n        = 5'h00;
			d.line     = 1'b1;
		end
	end

	// transmit fifo, receive buffer and receive fifo
	hlc_fifo u_txf (.mclk(mclk), .rst_n(rst_n), .flush(q.srst),
		.push(tx_push), .wdata(tx_ent), .full(tx_full), .pop(tx_pop),
		.head(tx_head), .valid(tx_valid), .count(tx_cnt));
	hlc_skid u_skid (.mclk(mclk), .rst_n(rst_n), .flush(q.srst),
		.s_valid(rx_push), .s_data(rx_ent), .s_ready(sk_ready),
		.m_valid(sk_valid), .m_data(sk_data), .m_ready(~rx_full));
	hlc_fifo u_rxf (.mclk(mclk), .rst_n(rst_n), .flush(q.srst),
		.push(sk_valid), .wdata(sk_data), .full(rx_full), .pop(rx_pop),
		.head(rx_head), .valid(rx_valid), .count(rx_cnt));

	// state register; the line marks while in reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q      <= '0;
			q.tst  <= hlc_pkg::TX_MARK;
			q.line <= 1'b1;
			q.txo  <= 1'b1;
		end else
			q <= d;
	end
	AST_IRQ_MASKED: assert property (@(posedge mclk)
		disable iff (!rst_n) !q.sel |=> !q.irq)
		else $error("interrupt raised while the unit is not selected");
endmodule : hlc_link_unit

/* File: rtl/hlc_regs.svh */
`ifndef HLC_REGS_SVH
`define HLC_REGS_SVH
// register offsets on the microprocessor port
`define HLC_OFS_CTRL1    5'h13
`define HLC_OFS_STAT     5'h14
`define HLC_OFS_CTRL2    5'h15
`define HLC_OFS_FIFO     5'h16
`define HLC_OFS_COUNT    5'h17
`define HLC_OFS_SRST     5'h1b
// link_control_one fields
`define HLC_C1_RX_EN     7
`define HLC_C1_TX_EN     5
`define HLC_C1_EOP       4
`define HLC_C1_FA        3
`define HLC_C1_IDLE      2
`define HLC_C1_LOOP_TR   1
`define HLC_C1_LOOP_RT   0
// controller_select and soft_reset_control fields
`define HLC_SEL_BIT      6
`define HLC_SRST_BIT     7
// link_control_two fields
`define HLC_C2_CYCLE     7
`define HLC_C2_RX_THR    6:4
`define HLC_C2_TX_THR    3:1
`define HLC_C2_CRC_INH   0
// receive_status_control read fields
`define HLC_ST_LAST      7
`define HLC_ST_BAD       6
`define HLC_ST_AVAIL     5
`define HLC_ST_NFULL     4
`define HLC_ST_NEMPTY    3
`define HLC_ST_UNDER     2
`define HLC_ST_OVFL      1
`define HLC_ST_GOAHEAD   0
// line patterns and checks
`define HLC_FLAG         8'h7e
`define HLC_ABORT_PAT    8'hfe
`define HLC_ONES         8'hff
`define HLC_CRC_INIT     16'hffff
`define HLC_CRC_POLY     16'h8408
`define HLC_CRC_GOOD     16'hf0b8
`define HLC_MIN_BITS     6'h19
`define HLC_ABORT_BITS   6'h1a
`define HLC_GOOD_BITS    6'h20
`define HLC_RUN_STUFF    4'h5
`define HLC_RUN_SIX      4'h6
`define HLC_RUN_SEVEN    4'h7
`define HLC_RUN_IDLE     4'hf
`define HLC_TX_STUFF     3'h5
`define HLC_THR_STEP     8'h10
`define HLC_DEPTH        8'h80
`endif

/* File: rtl/hlc_pkg.sv */
package hlc_pkg;
	// microprocessor request carrier
	typedef struct packed {
		logic       sel;
		logic       wr;
		logic       rd;
		logic [4:0] addr;
		logic [7:0] wdata;
	} hlc_bus_t;
	// receive fifo entry: two status bits above the byte
	typedef struct packed {
		logic       last;
		logic       bad;
		logic [7:0] data;
	} hlc_rx_ent_t;
	// transmit fifo entry: two tag bits above the byte
	typedef struct packed {
		logic       abort;
		logic       endp;
		logic [7:0] data;
	} hlc_tx_ent_t;
	// transmit unit being sent
	typedef enum logic [4:0] {
		TX_MARK  = 5'h01,
		TX_FLAG  = 5'h02,
		TX_DATA  = 5'h04,
		TX_FCS   = 5'h08,
		TX_ABORT = 5'h10
	} hlc_tx_st_t;
	typedef struct packed {
		logic [6:0] wr;
		logic [6:0] rd;
		logic [7:0] cnt;
		logic [9:0] head;
		logic       valid;
	} hlc_fifo_st_t;
	typedef struct packed {
		hlc_rx_ent_t e0;
		hlc_rx_ent_t e1;
		logic [1:0]  cnt;
	} hlc_skid_st_t;
	typedef struct packed {
		logic [7:0]  ctrl1, ctrl2, count, cnt_ld, rdata;
		logic        sel, srst, irq, underrun, overflow, goahead;
		logic        nfull, nempty;
		logic [2:0]  rxc, txc;
		logic [1:0]  rxd;
		logic        in_frame, blocked, rx_idle;
		logic [3:0]  ones;
		logic [6:0]  win;
		logic [2:0]  wcnt, bpos;
		logic [5:0]  bits;
		logic [7:0]  sr, h0, h1, h2;
		logic [1:0]  hcnt;
		logic [15:0] rcrc;
		hlc_tx_st_t  tst;
		logic [15:0] sh, tcrc;
		logic [4:0]  n;
		logic [2:0]  tones;
		logic [3:0]  lones;
		logic        line, txo, last_end, tx_idle;
	} hlc_st_t;
endpackage : hlc_pkg

/* File: rtl/hlc_fifo.sv */
`timescale 1ns/100ps
`include "hlc_regs.svh"
module hlc_fifo (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       flush,
	// write side
	input  wire logic       push,
	input  wire logic [9:0] wdata,
	output logic            full,
	// read side
	input  wire logic       pop,
	output logic [9:0]      head,
	output logic            valid,
	output logic [7:0]      count
);
	hlc_pkg::hlc_fifo_st_t q, d;
	logic [9:0]            mem [0:127];
	logic                  do_push;
	logic                  do_pop;

	assign full  = (q.cnt == `HLC_DEPTH);
	assign head  = q.head;
	assign valid = q.valid;
	assign count = q.cnt;

	// pointer update; head is registered from the post-pop slot
	always_comb begin
		d       = q;
		do_push = push & ~full;
		do_pop  = pop & q.valid;
		if (do_push)
			d.wr = q.wr + 7'h01;
		if (do_pop)
			d.rd = q.rd + 7'h01;
		d.cnt = q.cnt + {7'h00, do_push} - {7'h00, do_pop};
		d.head = (do_push && (q.wr == d.rd)) ? wdata : mem[d.rd];
		d.valid = (d.cnt != 8'h00);
		if (flush)
			d = '0;
	end

	// storage array, no reset needed
	always_ff @(posedge mclk) begin
		if (do_push)
			mem[q.wr] <= wdata;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	// occupancy checks
	default clocking fifo_cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	AST_FIFO_BOUND: assert property (q.cnt <= `HLC_DEPTH)
		else $error("fifo holds more words than its depth");
	AST_FIFO_GROW: assert property (push && !full && !pop && !flush
		|=> (count == $past(count) + 8'h01))
		else $error("accepted word was not counted");
	AST_FIFO_SHRINK: assert property (pop && valid && !push && !flush
		|=> (count == $past(count) - 8'h01))
		else $error("popped word was not uncounted");
endmodule : hlc_fifo

/* File: rtl/hlc_skid.sv */
`timescale 1ns/100ps
module hlc_skid (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         flush,
	// filling side
	input  wire logic         s_valid,
	input  hlc_pkg::hlc_rx_ent_t s_data,
	output logic              s_ready,
	// draining side
	output logic              m_valid,
	output hlc_pkg::hlc_rx_ent_t m_data,
	input  wire logic         m_ready
);
	hlc_pkg::hlc_skid_st_t q, d;
	logic                  take;
	logic                  give;

	assign s_ready = (q.cnt != 2'h2);
	assign m_valid = (q.cnt != 2'h0);
	assign m_data  = q.e0;

	// two slots, oldest in e0
	always_comb begin
		d    = q;
		take = s_valid & s_ready;
		give = m_valid & m_ready;
		if (give) begin
			d.e0 = q.e1;
			d.cnt = q.cnt - 2'h1;
		end
		if (take) begin
			if (d.cnt == 2'h0)
				d.e0 = s_data;
			else
				d.e1 = s_data;
			d.cnt = d.cnt + 2'h1;
		end
		if (flush)
			d = '0;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	// buffer checks
	default clocking skid_cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence s_into_empty;
		s_valid && (q.cnt == 2'h0) && !flush;
	endsequence : s_into_empty
	sequence s_full_stall;
		(q.cnt == 2'h2) && !m_ready && !flush;
	endsequence : s_full_stall
	AST_SKID_PASS: assert property (s_into_empty |=>
		(m_valid && (m_data == $past(s_data))))
		else $error("buffer did not present the word it took");
	AST_SKID_KEEP: assert property (s_full_stall |=>
		((q.cnt == 2'h2) && $stable(m_data)))
		else $error("stalled buffer changed its oldest word");
endmodule : hlc_skid

/* File: sim/hlc_station.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// remote station: makes both bit clocks, sends frames, decodes frames
module hlc_station (
	// bit clocks, free running like the data link clock
	output logic      tx_clk,
	output logic      rx_clk,
	// serial data
	output logic      rx_data,
	input  wire logic tx_data
);
	logic [7:0]  raw;
	logic [7:0]  v;
	logic [15:0] c;
	logic        bq[$];
	logic [7:0]  got[$];
	bit          got_ok;
	int          ones, so, n_frames, n_aborts;
	bit          infr;

	assign rx_clk = tx_clk;

	// clock and idle line
	initial begin
		tx_clk = 1'b0;
		rx_data = 1'b1;
		raw = 8'h00;
		{ones, so, n_frames, n_aborts, infr} = '0;
		forever #80 tx_clk = ~tx_clk;
	end

	// reflected crc-16 step over one byte, lsb first
	function automatic logic [15:0] crc_upd(logic [15:0] r, logic [7:0] d);
		for (int i = 0; i < 8; i++)
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ 16'h8408) : (r >> 1);
		return r;
	endfunction : crc_upd

	// data changes on the falling edge, read on the rising one
	task automatic put_bit(input logic b);
		@(negedge tx_clk);
		rx_data = b;
	endtask : put_bit

	task automatic put_byte(input logic [7:0] d, input bit stuff);
		for (int k = 0; k < 8; k++) begin
			put_bit(d[k]);
			so = (stuff && d[k]) ? so + 1 : 0;
			if (so == 5) begin
				put_bit(1'b0);
				so = 0;
			end
		end
	endtask : put_byte

	// one frame; corrupt flips a check bit
	task automatic send_frame(input logic [7:0] d[$], input bit corrupt);
		logic [15:0] r;
		r = 16'hffff;
		so = 0;
		put_byte(8'h7e, 1'b0);
		foreach (d[i]) begin
			r = crc_upd(r, d[i]);
			put_byte(d[i], 1'b1);
		end
		r = ~r ^ {15'h0000, corrupt};
		put_byte(r[7:0], 1'b1);
		put_byte(r[15:8], 1'b1);
		put_byte(8'h7e, 1'b0);
		repeat (16) put_bit(1'b1);
	endtask : send_frame

	// decoder: flag hunt, zero removal, abort and residue check
	always @(negedge tx_clk) begin
		raw = {tx_data, raw[7:1]};
		if (raw == 8'h7e) begin
			repeat (7) if (bq.size() > 0) void'(bq.pop_back());
			if (infr && bq.size() >= 24 && bq.size() % 8 == 0) begin
				got.delete();
				c = 16'hffff;
				for (int i = 0; i < bq.size(); i += 8) begin
					for (int j = 0; j < 8; j++) v[j] = bq[i + j];
					c = crc_upd(c, v);
					got.push_back(v);
				end
				got_ok = (c == 16'hf0b8);
				void'(got.pop_back());
				void'(got.pop_back());
				n_frames++;
			end
			bq.delete();
			infr = 1'b1;
			ones = 0;
		end else if (tx_data) begin
			ones++;
			if (ones >= 7 && infr) begin
				// seven ones right after a flag are idle, not an abort
				if (bq.size() > 6)
					n_aborts++;
				infr = 1'b0;
				bq.delete();
			end else bq.push_back(1'b1);
		end else begin
			if (ones != 5) bq.push_back(1'b0);
			ones = 0;
		end
	end
endmodule : hlc_station

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
`include "hlc_regs.svh"
module tb_top;
	logic              mclk, rst_n;
	hlc_pkg::hlc_bus_t bus;
	logic [7:0]        bus_rdata, q;
	logic              rxc, rxd, txc, txd, rx_idle, tx_idle, unit_irq;
	int                n_errors, n_checks;

	hlc_link_unit uut (.mclk(mclk), .rst_n(rst_n), .bus(bus),
		.bus_rdata(bus_rdata), .rx_clk_pin(rxc), .rx_data_pin(rxd),
		.tx_clk_pin(txc), .tx_data_pin(txd), .rx_idle(rx_idle),
		.tx_idle(tx_idle), .unit_irq(unit_irq));
	hlc_station st (.tx_clk(txc), .rx_clk(rxc), .rx_data(rxd),
		.tx_data(txd));

	////////////////////////////////////////////////////////////////////
	// clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one register access, held one cycle; data taken at that edge
	task automatic op(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus <= '{sel: 1'b1, wr: w, rd: ~w, addr: a, wdata: d};
		@(posedge mclk);
		bus <= '0;
		#1 q = bus_rdata;
	endtask : op

	// wait for the station to decode frame n, then compare it
	task automatic tx_expect(input logic [7:0] d[$], input int n);
		for (int k = 0; k < 4000 && st.n_frames < n; k++) @(posedge mclk);
		chk(st.n_frames[7:0], n[7:0]);
		chk(st.got.size(), d.size());
		foreach (d[i]) if (i < st.got.size()) chk(st.got[i], d[i]);
		chk({7'h00, st.got_ok}, 8'h01);
	endtask : tx_expect

	// drain one received frame through status and fifo reads
	task automatic rx_expect(input logic [7:0] d[$], input bit bad);
		repeat (100) @(posedge mclk);
		foreach (d[i]) begin
			op(1'b0, `HLC_OFS_STAT, 8'h00);
			if (i == d.size() - 1)
				chk({6'h00, q[`HLC_ST_LAST], q[`HLC_ST_BAD]}, {6'h00, 1'b1, bad});
			else if (!bad)
				chk({6'h00, q[`HLC_ST_LAST], q[`HLC_ST_BAD]}, 8'h00);
			op(1'b0, `HLC_OFS_FIFO, 8'h00);
			chk(q, d[i]);
		end
	endtask : rx_expect

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{n_errors, n_checks} = '0;
		bus = '0;
		q = 8'h00;
		rst_n = 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		op(1'b0, `HLC_OFS_CTRL1, 8'h00);
		chk(q, 8'h00);
		op(1'b0, `HLC_OFS_CTRL2, 8'h00);
		chk(q, 8'h00);
		chk({7'h00, unit_irq}, 8'h00);
		op(1'b1, `HLC_OFS_STAT, 8'h40);
		op(1'b1, `HLC_OFS_CTRL1, 8'ha0);
		chk({7'h00, unit_irq}, 8'h01);
		repeat (24) @(negedge txc);
		chk({7'h00, tx_idle}, 8'h01);
		chk(st.n_frames[7:0], 8'h00);
		// tagged packet with stuffing-heavy bytes
		op(1'b1, `HLC_OFS_FIFO, 8'hff);
		op(1'b1, `HLC_OFS_FIFO, 8'h7e);
		op(1'b1, `HLC_OFS_CTRL1, 8'hb0);
		op(1'b0, `HLC_OFS_CTRL1, 8'h00);
		chk(q, 8'hb0);
		op(1'b1, `HLC_OFS_FIFO, 8'h03);
		op(1'b0, `HLC_OFS_CTRL1, 8'h00);
		chk(q, 8'ha0);
		tx_expect('{8'hff, 8'h7e, 8'h03}, 1);
		// abort tag: one byte before it, then an abort
		op(1'b1, `HLC_OFS_FIFO, 8'h11);
		op(1'b1, `HLC_OFS_CTRL1, 8'ha8);
		op(1'b1, `HLC_OFS_FIFO, 8'h22);
		repeat (3000) @(posedge mclk);
		chk(st.n_aborts[7:0], 8'h01);
		chk(st.n_frames[7:0], 8'h01);
		// byte counter ends the packet
		op(1'b1, `HLC_OFS_COUNT, 8'h02);
		op(1'b1, `HLC_OFS_FIFO, 8'h33);
		op(1'b1, `HLC_OFS_FIFO, 8'h44);
		tx_expect('{8'h33, 8'h44}, 2);
		repeat (24) @(negedge txc);
		chk({7'h00, tx_idle}, 8'h01);
		// receive: good, bad check, short
		st.send_frame('{8'hff, 8'h03, 8'h7e}, 1'b0);
		rx_expect('{8'hff, 8'h03, 8'h7e}, 1'b0);
		chk({7'h00, rx_idle}, 8'h01);
		st.send_frame('{8'h12, 8'h34, 8'h56}, 1'b1);
		rx_expect('{8'h12, 8'h34, 8'h56}, 1'b1);
		st.send_frame('{8'h55}, 1'b0);
		repeat (100) @(posedge mclk);
		op(1'b0, `HLC_OFS_STAT, 8'h00);
		chk({7'h00, q[`HLC_ST_AVAIL]}, 8'h00);
		// soft reset clears control
		op(1'b1, `HLC_OFS_SRST, 8'h80);
		op(1'b1, `HLC_OFS_SRST, 8'h00);
		op(1'b0, `HLC_OFS_CTRL1, 8'h00);
		chk(q, 8'h00);
		tally_and_finish();
	end

	// watchdog well beyond the expected run
	initial begin
		#400000;
		n_errors++;
		tally_and_finish();
	end
endmodule : tb_top
